//--- rtl/cch_pkg.sv
// Package: shared types and constants for the component call handshake
// ==========================================================================
// Notes on behaviour
// - Call port is a start input answered by a busy output.
// - Return port is a done output answered by a stall input.
// - A non-void result is driven on return data beside done.
// - Each scalar argument is an input conduit sampled with start and busy.
// - Arguments are captured only when start is high and busy is low.
// - Each pointer argument is an address conduit captured like scalars.
// - All pointer arguments share one memory-mapped master port.
// - While stall is high, done stays high and return data holds.
package cch_pkg;
	// ======================================================================
	// Widths
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int IDX_W  = 32;
	// ======================================================================
	// Reset values and word addressing
	localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST   = 32'h0000_0000;
	localparam int                WORD_BYTES = 4;
	localparam logic [1:0]        ADDR_SHIFT = 2'h2;

	// Call arguments: scalar a, pointer b, scalar index i
	typedef struct packed {
		logic [DATA_W-1:0] a;
		logic [ADDR_W-1:0] b;
		logic [IDX_W-1:0]  i;
	} cch_args_t;

	// Shared memory master request and response
	typedef struct packed {
		logic              read;
		logic [ADDR_W-1:0] address;
	} cch_mm_req_t;

	typedef struct packed {
		logic              readdatavalid;
		logic [DATA_W-1:0] readdata;
		logic              waitrequest;
	} cch_mm_rsp_t;

	// Controller states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_REQ  = 4'h2,
		ST_WAIT = 4'h4,
		ST_DONE = 4'h8
	} cch_state_t;
endpackage

//--- rtl/cch_mm_port.sv
// Shared memory-mapped master port: one read at a time, data latched
`timescale 1ns/1ps
module cch_mm_port
	import cch_pkg::*;
(
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic                      req_valid,
	input  wire logic [cch_pkg::ADDR_W-1:0] req_addr,
	output logic                           req_ready,
	output logic                           rsp_valid,
	output logic [cch_pkg::DATA_W-1:0]     rsp_data,
	output cch_pkg::cch_mm_req_t           mm_req,
	input  wire cch_pkg::cch_mm_rsp_t      mm_rsp
);
	// ======================================================================
	// Request holding
	logic pending;
	wire  issue_ok = mm_req.read & ~mm_rsp.waitrequest;

	// Only one outstanding read, so no response tagging is needed
	assign req_ready = ~mm_req.read & ~pending;

	// Read strobe holds until the slave stops asserting waitrequest
	always_ff @(posedge mclk) begin
		if (rst) begin
			mm_req    <= '0;
			pending   <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data  <= RESULT_RST;
		end else begin
			rsp_valid <= 1'b0;
			if (req_valid && req_ready) begin
				mm_req.read    <= 1'b1;
				mm_req.address <= req_addr;
			end else if (issue_ok) begin
				mm_req.read <= 1'b0;
				pending     <= 1'b1;
			end
			if (pending && mm_rsp.readdatavalid) begin
				pending   <= 1'b0;
				rsp_valid <= 1'b1;
				rsp_data  <= mm_rsp.readdata;
			end
		end
	end

	// ======================================================================
	// Checks
	// Only one read may be open at a time, since answers carry no tag
	a_one_outstanding: assert property (@(posedge mclk) disable iff (rst)
		pending |-> !mm_req.read)
		else $error("read issued while one is pending");

	// Strobe and address hold while the memory asks to wait
	a_read_holds: assert property (@(posedge mclk) disable iff (rst)
		mm_req.read && mm_rsp.waitrequest |=> mm_req.read && $stable(mm_req.address))
		else $error("read request changed under waitrequest");
endmodule

//--- rtl/cch_top.sv
// Component with call and return handshakes: returns a times b[i]
`timescale 1ns/1ps
module cch_top
	import cch_pkg::*;
(
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic                       start,
	output logic                            busy,
	input  wire cch_pkg::cch_args_t         args,
	output logic                            done,
	input  wire logic                       stall,
	output logic [cch_pkg::DATA_W-1:0]      returndata,
	output cch_pkg::cch_mm_req_t            mm_req,
	input  wire cch_pkg::cch_mm_rsp_t       mm_rsp
);
	// ======================================================================
	// Call and return decode
	cch_state_t        state;
	cch_state_t        next_state;
	cch_args_t         held;
	logic              rsp_valid;
	logic [DATA_W-1:0] rsp_data;
	logic              req_ready;

	// Busy whenever not idle; reset also shows busy so no call is taken
	assign busy = rst | (state != ST_IDLE);
	wire call_take = start & ~busy;
	wire delivered = done & ~stall;
	wire req_valid = (state == ST_REQ);
	wire [ADDR_W-1:0] elem_addr = held.b + ADDR_W'(held.i << ADDR_SHIFT);

	// ======================================================================
	// Next state
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: if (call_take) next_state = ST_REQ;
			ST_REQ:  if (req_ready) next_state = ST_WAIT;
			ST_WAIT: if (rsp_valid) next_state = ST_DONE;
			ST_DONE: if (delivered) next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// Arguments captured once per call, so caller may change them after
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			held  <= '0;
		end else begin
			state <= next_state;
			if (call_take) held <= args;
		end
	end

	// Result register; frozen while done is high so stall holds it
	always_ff @(posedge mclk) begin
		if (rst) begin
			done       <= 1'b0;
			returndata <= RESULT_RST;
		end else if (state == ST_WAIT && rsp_valid) begin
			done       <= 1'b1;
			returndata <= DATA_W'(held.a * rsp_data);
		end else if (delivered) begin
			done <= 1'b0;
		end
	end

	// ======================================================================
	// Shared memory master for all pointer arguments
	cch_mm_port u_mm (
		.mclk      (mclk),
		.rst       (rst),
		.req_valid (req_valid),
		.req_addr  (elem_addr),
		.req_ready (req_ready),
		.rsp_valid (rsp_valid),
		.rsp_data  (rsp_data),
		.mm_req    (mm_req),
		.mm_rsp    (mm_rsp)
	);

	// ======================================================================
	// Checks: reads issued per call, so a second read on one pointer shows up
	// Counter saturates at three so a runaway request never wraps back to one
	logic [1:0] reads_in_call;
	logic [1:0] next_reads_in_call;
	wire        read_issue = req_valid & req_ready;
	wire        read_room  = (reads_in_call != 2'h3);
	wire  [1:0] read_inc   = reads_in_call + 2'h1;

	// Next count: cleared by a taken call, bumped by each request handed over
	always_comb begin
		next_reads_in_call = reads_in_call;
		if (call_take) begin
			next_reads_in_call = 2'h0;
		end else if (read_issue && read_room) begin
			next_reads_in_call = read_inc;
		end
	end

	// Count register
	always_ff @(posedge mclk) begin
		if (rst) begin
			reads_in_call <= 2'h0;
		end else begin
			reads_in_call <= next_reads_in_call;
		end
	end

	// ======================================================================
	// Call port checks
	// State must stay one-hot; a stray code shows busy for one cycle before the default branch returns to idle
	a_state_onehot: assert property (@(posedge mclk) disable iff (rst)
		$onehot(state))
		else $error("controller state not one-hot");

	// A taken call shows busy in the next cycle
	a_call_busy: assert property (@(posedge mclk) disable iff (rst)
		start && !busy |=> busy)
		else $error("call not taken");

	// Arguments land in the holding register on the taking edge
	a_capture_arg: assert property (@(posedge mclk) disable iff (rst)
		start && !busy |=> held == $past(args))
		else $error("arguments not captured");

	// Outside a taking edge the held arguments never move
	a_held_stable: assert property (@(posedge mclk) disable iff (rst)
		!call_take |=> $stable(held))
		else $error("arguments captured without a call");

	// Busy falls together with done, so the next call can be taken at once
	a_busy_idle: assert property (@(posedge mclk) disable iff (rst)
		$fell(done) |-> !busy && state == ST_IDLE)
		else $error("busy held after delivery");

	// Reset leaves the controller idle with the memory port quiet
	a_reset_idle: assert property (@(posedge mclk)
		rst |=> state == ST_IDLE && !mm_req.read)
		else $error("controller not idle after reset");

	// Done is low once reset has been seen
	a_reset_done: assert property (@(posedge mclk)
		rst |=> !done)
		else $error("done after reset");

	// ======================================================================
	// Pointer and memory checks
	// The read address is the pointer plus the scaled index
	a_addr_ptr: assert property (@(posedge mclk) disable iff (rst)
		$rose(mm_req.read) |-> mm_req.address == elem_addr)
		else $error("wrong pointer address");

	// One pointer argument, so exactly one read is issued per call
	a_single_read: assert property (@(posedge mclk) disable iff (rst)
		reads_in_call < 2'h2)
		else $error("more than one read in a call");

	// A result is only produced after its read was issued
	a_read_before_done: assert property (@(posedge mclk) disable iff (rst)
		$rose(done) |-> reads_in_call == 2'h1)
		else $error("result without a memory read");

	// The request state waits for the port before any strobe is raised
	a_req_quiet: assert property (@(posedge mclk) disable iff (rst)
		state == ST_REQ |-> !mm_req.read)
		else $error("read raised before the request was handed over");

	// No memory traffic while idle
	a_no_read_idle: assert property (@(posedge mclk) disable iff (rst)
		state == ST_IDLE |-> !mm_req.read && !rsp_valid)
		else $error("memory activity while idle");

	// Memory answers are only expected while waiting for one
	a_rsp_wait: assert property (@(posedge mclk) disable iff (rst)
		rsp_valid |-> state == ST_WAIT)
		else $error("memory answer outside the wait state");

	// The read is over before the result is offered
	a_done_quiet: assert property (@(posedge mclk) disable iff (rst)
		done |-> !mm_req.read)
		else $error("read still open while done");

	// ======================================================================
	// Return port checks
	// Done is only shown from the done state
	a_done_state: assert property (@(posedge mclk) disable iff (rst)
		done |-> state == ST_DONE)
		else $error("done outside the done state");

	// Done implies the call is still in progress
	a_done_busy: assert property (@(posedge mclk) disable iff (rst)
		done |-> busy)
		else $error("done while idle");

	// Done rises only the cycle after a memory answer
	a_done_from_rsp: assert property (@(posedge mclk) disable iff (rst)
		$rose(done) |-> $past(rsp_valid))
		else $error("done without a memory answer");

	// Result is the scalar times the word read
	a_result_val: assert property (@(posedge mclk) disable iff (rst)
		$rose(done) |-> returndata == DATA_W'(held.a * $past(rsp_data)))
		else $error("bad result");

	// Return data stays put for as long as done stands
	a_ret_stable: assert property (@(posedge mclk) disable iff (rst)
		done && $past(done) |-> $stable(returndata))
		else $error("return data moved while done");

	// Under stall both done and return data hold
	a_stall_holds: assert property (@(posedge mclk) disable iff (rst)
		done && stall |=> done && $stable(returndata))
		else $error("done dropped under stall");

	// Under stall the controller stays in the done state
	a_stall_state: assert property (@(posedge mclk) disable iff (rst)
		done && stall |=> state == ST_DONE)
		else $error("controller left done under stall");

	// Delivery drops done in the next cycle
	a_done_clears: assert property (@(posedge mclk) disable iff (rst)
		done && !stall |=> !done)
		else $error("done stuck after delivery");
endmodule

//--- sim/cch_mem_model.sv
// Memory model behind the shared read port of the component
`timescale 1ns/1ps
module cch_mem_model
	import cch_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 slow,
	input  wire cch_pkg::cch_mm_req_t mm_req,
	output cch_pkg::cch_mm_rsp_t      mm_rsp
);
	import cch_pkg::*;
	logic              held;
	logic              rdv;
	logic [DATA_W-1:0] rd;
	logic              wr;
	// ==========================
	// Answer: slow mode stalls each read for one cycle
	assign wr     = mm_req.read & slow & ~held;
	assign mm_rsp = '{rdv, rd, wr};
	// Data flips every cycle outside the valid cycle, so a stale value shows only on alternate cycles
	always_ff @(posedge mclk) begin
		held <= mm_req.read & wr & ~rst;
		rdv  <= mm_req.read & ~wr & ~rst;
		rd   <= (mm_req.read & ~wr) ? (mm_req.address ^ 32'hc3a5_0f1e) : ~rd;
	end
endmodule

//--- sim/cch_top_test.sv
// Testbench for the component call and return handshakes
`timescale 1ns/1ps
module cch_top_test;
	import cch_pkg::*;
	logic              mclk  = 1'b0;
	logic              rst   = 1'b1;
	logic              start = 1'b0;
	logic              stall = 1'b0;
	logic              slow  = 1'b0;
	cch_args_t         args  = '0;
	logic              busy;
	logic              done;
	logic [DATA_W-1:0] returndata;
	cch_mm_req_t       mm_req;
	cch_mm_rsp_t       mm_rsp;
	int                mismatches = 0;
	int                num_checks = 0;
	// ==========================
	// Clock, design and memory
	always #4 mclk = ~mclk;
	cch_top DUT (.mclk(mclk), .rst(rst), .start(start), .busy(busy), .args(args), .done(done),
		.stall(stall), .returndata(returndata), .mm_req(mm_req), .mm_rsp(mm_rsp));
	cch_mem_model mem (.mclk(mclk), .rst(rst), .slow(slow), .mm_req(mm_req), .mm_rsp(mm_rsp));
	// ==========================
	// Compare and verdict
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ==========================
	// One call; start and args held until the taking edge, then args scrambled
	task automatic do_call(input logic [31:0] a, input logic [31:0] b, input logic [31:0] i, input int nst);
		logic [DATA_W-1:0] exp;
		exp = a * ((b + (i << 2)) ^ 32'hc3a5_0f1e);
		@(negedge mclk);
		chk(32'(busy), 32'h0);
		start = 1'b1;
		args  = '{a, b, i};
		@(negedge mclk);
		chk(32'(busy), 32'h1);
		start = 1'b0;
		args  = '{~a, ~b, ~i};
		finish_call(exp, nst);
	endtask
	// Wait for done, hold it under stall for nst cycles, then see it delivered
	task automatic finish_call(input logic [DATA_W-1:0] exp, input int nst);
		int n;
		n = 0;
		while (done !== 1'b1 && n < 60) begin
			@(negedge mclk);
			n++;
		end
		chk(32'(done), 32'h1);
		stall = (nst > 0);
		repeat (nst) begin
			@(negedge mclk);
			chk(32'(done), 32'h1);
			chk(returndata, exp);
		end
		stall = 1'b0;
		chk(returndata, exp);
		@(negedge mclk);
		chk(32'(done), 32'h0);
	endtask
	// Reset holds busy high and done low, then frees the call port
	task automatic test_reset();
		rst = 1'b1;
		repeat (4) @(negedge mclk);
		chk(32'(busy), 32'h1);
		chk(32'(done), 32'h0);
		chk(32'(mm_req.read), 32'h0);
		rst = 1'b0;
	endtask
	// Prompt memory, scalar and pointer arguments
	task automatic test_prompt();
		slow = 1'b0;
		do_call(32'h5, 32'h100, 32'h3, 0);
	endtask
	// Slow memory with a stalled consumer
	task automatic test_stall();
		slow = 1'b1;
		do_call(32'hffff_ffff, 32'h2000, 32'h0, 3);
	endtask
	// Calls following one another with new arguments
	task automatic test_b2b();
		do_call(32'h7, 32'h40, 32'hffff_ffff, 1);
		do_call(32'h0, 32'h80, 32'h1, 0);
	endtask
	// Call presented during reset: start and args held through reset until the taking edge
	task automatic test_early_call();
		rst   = 1'b1;
		start = 1'b1;
		args  = '{32'h3, 32'h300, 32'h2};
		repeat (4) @(negedge mclk);
		chk(32'(busy), 32'h1);
		chk(32'(done), 32'h0);
		rst = 1'b0;
		@(negedge mclk);
		chk(32'(busy), 32'h1);
		start = 1'b0;
		finish_call(32'h3 * ((32'h300 + (32'h2 << 2)) ^ 32'hc3a5_0f1e), 2);
	endtask
	// ==========================
	// Main sequence and watchdog
	initial begin
		test_reset();
		test_prompt();
		test_stall();
		test_reset();
		test_b2b();
		test_early_call();
		final_report();
	end
	initial begin
		#100000;
		mismatches++;
		final_report();
	end
endmodule
